// >>> sim/tb.sv
// tb: self-checking bench for rac_core over wishbone and the sample stream
// assumes ack one cycle after a request and ready 35/37 cycles after a take
module tb import rac_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ns;

	// ---------------------------------------------------------------
	// signals
	// ---------------------------------------------------------------
	logic        clk_i;
	logic        rst_i;
	logic        ce_i;
	logic        cyc;
	logic        stb;
	logic        we;
	logic [15:0] adr;
	logic [3:0]  sel;
	logic [31:0] wdat;
	logic [31:0] rdat;
	logic        ack;
	logic        sv;
	logic [1:0]  sch;
	logic [23:0] sdat;
	logic        srdy;
	logic [31:0] a;
	logic [31:0] b;
	logic [31:0] d;
	logic [63:0] p;
	int          bad_count;
	int          n_tests;

	// rows: index, lanes, write data, value read back
	logic [13:0] r_ix [13] = '{IX_CTL1, IX_CTL3, IX_DET, IX_BPC, IX_BPC,
		14'h0001, IX_RGAIN, IX_INST, IX_BPC, IX_CTL1, IX_CTL3, IX_DET,
		IX_RGAIN};
	logic [3:0]  r_sel [13] = '{4'hF, 4'hF, 4'hF, 4'hF, 4'h1, 4'hF, 4'hF,
		4'hF, 4'hF, 4'hF, 4'hF, 4'hF, 4'hF};
	logic [31:0] r_wd [13] = '{32'hFFFFFF4A, 32'h000000A5, 32'h0000003C,
		32'h911D3C9C, 32'hFFFFFFFF, 32'h12345678, 32'h40000000,
		32'hFFFFFFFF, RST_BPC, 32'h0, 32'h0, 32'h0, 32'h0};
	logic [31:0] r_ex [13] = '{32'h0000004A, 32'h000000A5, 32'h0000003C,
		32'h911D3C9C, 32'h911D3CFF, 32'h0, 32'h40000000, 32'h0, RST_BPC,
		32'h0, 32'h0, 32'h0, 32'h0};
	logic [13:0] z_ix [13] = '{IX_BPC, IX_CTL1, IX_CTL3, IX_DET, IX_INST,
		IX_INST + 14'h1, IX_INST + 14'h2, IX_AVG, IX_AVG + 14'h1,
		IX_AVG + 14'h2, IX_APP, IX_PWR, IX_PWR + 14'h1};

	rac_core dut (
		.clk_i       (clk_i),
		.rst_i       (rst_i),
		.ce_i        (ce_i),
		.wb_cyc_i    (cyc),
		.wb_stb_i    (stb),
		.wb_we_i     (we),
		.wb_adr_i    (adr),
		.wb_sel_i    (sel),
		.wb_dat_i    (wdat),
		.wb_dat_o    (rdat),
		.wb_ack_o    (ack),
		.smp_valid_i (sv),
		.smp_chan_i  (sch),
		.smp_data_i  (sdat),
		.smp_ready_o (srdy)
	);

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	task automatic chk(input string nm, input logic [31:0] e, g);
		n_tests++;
		if (g !== e) begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic bus(input logic [13:0] ix, input logic w,
		input logic [3:0] s, input logic [31:0] dw,
		output logic [31:0] dr);
		int n;
		n = 0;
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= {ix, 2'b00};
		sel <= s;
		wdat <= dw;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack !== 1'b1 && n < 50);
		dr = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		if (ack !== 1'b1) chk("bus ack", 32'h1, 32'h0);
	endtask

	task automatic wr(input logic [13:0] ix, input logic [31:0] dw);
		logic [31:0] x;
		bus(ix, 1'b1, 4'hF, dw, x);
	endtask

	task automatic rd(input logic [13:0] ix, output logic [31:0] dr);
		bus(ix, 1'b0, 4'hF, 32'h0, dr);
	endtask

	// offer one sample, then time the return of ready
	task automatic send(input logic [1:0] ch, input logic [23:0] v);
		int n;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (srdy !== 1'b1 && n < 100);
		sv <= 1'b1;
		sch <= ch;
		sdat <= v;
		@(posedge clk_i);
		sv <= 1'b0;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (srdy !== 1'b1 && n < 100);
		chk("ready latency", (ch == CH_U) ? 32'd37 : 32'd35, n);
	endtask

	task automatic rounds(input int k);
		for (int i = 0; i < k; i++) begin
			send(CH_I1, 24'h100000);
			send(CH_I2, 24'h100000);
			send(CH_U, 24'h100000);
		end
	endtask

	task automatic complete_run;
		if (bad_count == 0 && n_tests > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// ---------------------------------------------------------------
	// clock, watchdog, sequence
	// ---------------------------------------------------------------
	initial begin
		clk_i = 1'b0;
		forever #25 clk_i = ~clk_i;
	end

	initial begin
		repeat (60000) @(posedge clk_i);
		bad_count++;
		complete_run();
	end

	initial begin
		rst_i = 1'b1;
		ce_i = 1'b1;
		cyc = 1'b0;
		stb = 1'b0;
		we = 1'b0;
		adr = 16'h0;
		sel = 4'h0;
		wdat = 32'h0;
		sv = 1'b0;
		sch = 2'h0;
		sdat = 24'h0;
		bad_count = 0;
		n_tests = 0;
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		for (int i = 0; i < 13; i++) begin
			rd(z_ix[i], d);
			chk("reset value", 32'h0, d);
		end
		for (int i = 0; i < 13; i++) begin
			bus(r_ix[i], 1'b1, r_sel[i], r_wd[i], d);
			rd(r_ix[i], d);
			chk("register row", r_ex[i], d);
		end
		// samples offered while disabled are refused
		sv <= 1'b1;
		sch <= CH_I1;
		sdat <= 24'h100000;
		repeat (20) @(posedge clk_i);
		chk("ready while off", 32'h0, {31'h0, srdy});
		sv <= 1'b0;
		wr(IX_RGAIN + 14'h2, 32'h80000000);
		wr(IX_CTL1, 32'h00000010);
		rounds(60);
		rd(IX_INST + 14'h1, a);
		chk("inst i1 nonzero", 32'h1, {31'h0, |a});
		rd(IX_INST + 14'h2, d);
		chk("inst i2 gain -1", 32'h0, d);
		rd(IX_AVG + 14'h2, d);
		chk("avg i2", 32'h0, d);
		rd(IX_PWR, d);
		chk("pwr1 positive", 32'h0, {31'h0, d[31]});
		rd(IX_PWR + 14'h1, d);
		chk("pwr2 reactive sign", 32'h1, {31'h0, d[31]});
		rd(IX_AVG + 14'h1, a);
		chk("avg i1 nonzero", 32'h1, {31'h0, |a});
		rd(IX_AVG, b);
		rd(IX_APP, d);
		p = {32'h0, a} * {32'h0, b};
		chk("apparent", p[63:32], d);
		// disabled: results hold, nothing taken
		rd(IX_INST + 14'h1, a);
		wr(IX_CTL1, 32'h0);
		sv <= 1'b1;
		sch <= CH_I1;
		sdat <= 24'h7FFFFF;
		repeat (40) @(posedge clk_i);
		chk("ready disabled", 32'h0, {31'h0, srdy});
		sv <= 1'b0;
		rd(IX_INST + 14'h1, b);
		chk("inst hold", a, b);
		// gate_off stops the engine even when enabled
		wr(IX_CTL1, 32'h00000010);
		// the pulse threshold sits outside this block, so gating needs no setup
		wr(IX_DET, 32'h00000080);
		repeat (40) @(posedge clk_i);
		chk("ready gated", 32'h0, {31'h0, srdy});
		wr(IX_DET, 32'h0);
		// second path switched to active power on the second current
		wr(IX_CTL3, 32'h00000010);
		rounds(60);
		rd(IX_PWR + 14'h1, d);
		chk("pwr2 active sign", 32'h0, {31'h0, d[31]});
		// bandpass removes the constant part, so rms must fall
		rd(IX_INST + 14'h1, a);
		wr(IX_CTL3, 32'h00000050);
		rounds(40);
		rd(IX_INST + 14'h1, b);
		chk("bandpass rms drop", 32'h1, {31'h0, b < a});
		// gain -1 leaves only the offset
		wr(IX_PGAIN, 32'h80000000);
		wr(IX_POFF, 32'h00001234);
		send(CH_U, 24'h100000);
		rd(IX_PWR, d);
		chk("pwr1 gain offset", 32'h00001234, d);
		// clock enable low: the offered sample must stay untaken
		rd(IX_INST + 14'h1, a);
		ce_i <= 1'b0;
		sv <= 1'b1;
		sch <= CH_I1;
		sdat <= 24'h7FFFFF;
		repeat (20) @(posedge clk_i);
		chk("ready frozen", 32'h1, {31'h0, srdy});
		sv <= 1'b0;
		ce_i <= 1'b1;
		repeat (40) @(posedge clk_i);
		rd(IX_INST + 14'h1, b);
		chk("inst frozen", a, b);
		// a reset in mid-run clears every result
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		rd(IX_AVG + 14'h1, d);
		chk("avg after reset", 32'h0, d);
		rd(IX_APP, d);
		chk("app after reset", 32'h0, d);
		complete_run();
	end
endmodule

// >>> verilog/rac_core.sv
// rac_core: rms, apparent power and two power paths behind wishbone
// assumes a same-clock sample stream and a classic wishbone master
//
// Local design decision: register access over Wishbone.
module rac_core import rac_pkg::*; (
	// clock, reset, enable
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        ce_i,
	// wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [15:0] wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic [31:0]      wb_dat_o,
	output logic             wb_ack_o,
	// high-pass filtered sample stream
	input  wire logic        smp_valid_i,
	input  wire logic [1:0]  smp_chan_i,
	input  wire logic [23:0] smp_data_i,
	output logic             smp_ready_o
);

	typedef struct packed {
		logic [7:0]        ctl1;
		logic [7:0]        ctl3;
		logic [7:0]        det;
		logic [31:0]       bpc;
		logic [2:0][31:0]  rgain;
		logic [1:0][31:0]  pgain;
		logic [1:0][31:0]  poff;
		logic [2:0][31:0]  inst;
		logic [2:0][31:0]  avg;
		logic [31:0]       app;
		logic [1:0][31:0]  pwr;
		logic [1:0][31:0]  plpf;
		logic [2:0][63:0]  lpf;
		logic [2:0][23:0]  xp;
		logic [2:0][31:0]  yp;
		logic [23:0]       u;
		logic [23:0]       i1;
		logic [23:0]       i2;
		logic [31:0]       integ;
		rac_state_e        st;
		logic [1:0]        ch;
		logic              ack;
		logic [31:0]       dat;
		logic              rdy;
	} rac_core_s;

	rac_core_s          r;
	rac_core_s          next_r;
	logic [13:0]        idx;
	logic               req;
	logic               run;
	logic               take;
	logic [1:0]         cs;
	logic [31:0]        rd;
	logic [31:0]        gx;
	logic [31:0]        gs;
	logic [31:0]        gain_y;
	logic [31:0]        root;
	logic               sq_done;
	logic signed [31:0] xs;
	logic signed [31:0] ye;
	logic signed [63:0] bprod;
	logic signed [63:0] sq;
	logic [64:0]        ld;
	logic [63:0]        lpf_n;
	logic signed [63:0] p1;
	logic signed [63:0] p2a;
	logic signed [63:0] p2q;
	logic [31:0]        p2;
	logic signed [63:0] app_prod;

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	function automatic logic [31:0] wm(logic [31:0] o, logic [31:0] d,
			logic [3:0] s);
		for (int b = 0; b < 4; b++) begin
			if (s[b])
				o[8*b +: 8] = d[8*b +: 8];
		end
		return o;
	endfunction
	// first-order tracking step: o + (n - o) / 2^sh
	function automatic logic [31:0] step(logic [31:0] o, logic [31:0] n,
			int sh);
		logic signed [32:0] d;
		d = $signed({n[31], n}) - $signed({o[31], o});
		d = d >>> sh;
		return o + d[31:0];
	endfunction
	// ---------------------------------------------------------------
	// shared arithmetic units
	// ---------------------------------------------------------------
	rac_sqrt u_sqrt (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.ce_i    (ce_i),
		.start_i (take),
		.rad_i   (lpf_n),
		.done_o  (sq_done),
		.root_o  (root)
	);
	rac_gain u_gain (
		.x_i (gx),
		.s_i (gs),
		.y_o (gain_y)
	);

	// ---------------------------------------------------------------
	// next state
	// ---------------------------------------------------------------
	always_comb begin
		next_r = r;
		// register bus
		idx = wb_adr_i[15:2];
		req = wb_cyc_i & wb_stb_i & ~r.ack;
		rd = 32'h0;
		case (idx)
			IX_BPC:  rd = r.bpc;
			IX_CTL1: rd = {24'h0, r.ctl1};
			IX_CTL3: rd = {24'h0, r.ctl3};
			IX_DET:  rd = {24'h0, r.det};
			IX_APP:  rd = r.app;
			default: rd = 32'h0;
		endcase
		for (int k = 0; k < 3; k++) begin
			if (idx == IX_RGAIN + 14'(k))
				rd = r.rgain[k];
			if (idx == IX_INST + 14'(k))
				rd = r.inst[k];
			if (idx == IX_AVG + 14'(k))
				rd = r.avg[k];
		end
		for (int k = 0; k < 2; k++) begin
			if (idx == IX_PGAIN + 14'(k))
				rd = r.pgain[k];
			if (idx == IX_POFF + 14'(k))
				rd = r.poff[k];
			if (idx == IX_PWR + 14'(k))
				rd = r.pwr[k];
		end
		next_r.ack = req;
		next_r.dat = rd;
		if (req & wb_we_i) begin
			if (wb_sel_i[0] && idx == IX_CTL1)
				next_r.ctl1 = wb_dat_i[7:0];
			if (wb_sel_i[0] && idx == IX_CTL3)
				next_r.ctl3 = wb_dat_i[7:0];
			if (wb_sel_i[0] && idx == IX_DET)
				next_r.det = wb_dat_i[7:0];
			// held until software reprograms it for a clock change
			if (idx == IX_BPC)
				next_r.bpc = wm(r.bpc, wb_dat_i, wb_sel_i);
			for (int k = 0; k < 3; k++) begin
				if (idx == IX_RGAIN + 14'(k))
					next_r.rgain[k] = wm(r.rgain[k], wb_dat_i, wb_sel_i);
			end
			for (int k = 0; k < 2; k++) begin
				if (idx == IX_PGAIN + 14'(k))
					next_r.pgain[k] = wm(r.pgain[k], wb_dat_i, wb_sel_i);
				if (idx == IX_POFF + 14'(k))
					next_r.poff[k] = wm(r.poff[k], wb_dat_i, wb_sel_i);
			end
		end
		// datapath terms
		run = r.ctl1[B_POWER_CALC_ENABLE] & ~r.det[B_GT];
		cs = (smp_chan_i == 2'h3) ? CH_U : smp_chan_i;
		take = r.rdy & smp_valid_i & run & (smp_chan_i != 2'h3);
		xs = {{8{smp_data_i[23]}}, smp_data_i};
		bprod = $signed(r.bpc) * $signed(r.yp[cs]);
		if (r.ctl3[B_BANDPASS_ENABLE])
			ye = xs - $signed({{8{r.xp[cs][23]}}, r.xp[cs]})
				+ $signed(bprod[62:31]);
		else
			ye = xs;
		sq = ye * ye;
		ld = {1'b0, sq} - {1'b0, r.lpf[cs]};
		lpf_n = r.lpf[cs] + 64'($signed(ld) >>> LPF_SH);
		p1 = $signed(r.u) * $signed(r.i1);
		p2a = $signed(r.u) * $signed(r.i2);
		p2q = $signed(r.u) * $signed(r.integ);
		if (r.ctl3[B_DBL])
			p2 = p2a[47:16];
		else
			p2 = 32'h0 - p2q[55:24];
		app_prod = $signed(r.avg[CH_I1]) * $signed(r.avg[CH_U]);
		// gain operand select follows the sequencer
		case (r.st)
			ST_PWR1: begin
				gx = r.plpf[0];
				gs = r.pgain[0];
			end
			ST_PWR2: begin
				gx = r.plpf[1];
				gs = r.pgain[1];
			end
			default: begin
				gx = root;
				gs = r.rgain[r.ch];
			end
		endcase
		// sequencer; a stopped engine decodes as idle and writes nothing
		case (run ? r.st : ST_IDLE)
			ST_IDLE: begin
				if (take) begin
					next_r.lpf[cs] = lpf_n;
					next_r.xp[cs] = smp_data_i;
					next_r.yp[cs] = ye;
					next_r.ch = cs;
					if (cs == CH_U)
						next_r.u = smp_data_i;
					if (cs == CH_I2)
						next_r.i2 = smp_data_i;
					if (cs == CH_I1) begin
						next_r.i1 = smp_data_i;
						// leaky integrator gives the quadrature current
						next_r.integ = $signed(r.integ) + xs
							- ($signed(r.integ) >>> INT_SH);
					end
					next_r.st = ST_ROOT;
				end
			end
			ST_ROOT: begin
				if (sq_done)
					next_r.st = ST_RCAL;
			end
			ST_RCAL: begin
				next_r.inst[r.ch] = gain_y;
				next_r.avg[r.ch] = step(r.avg[r.ch], gain_y,
					AVG_SH);
				next_r.st = (r.ch == CH_U) ? ST_PWR1 : ST_IDLE;
			end
			ST_PWR1: begin
				next_r.plpf[0] = step(r.plpf[0], p1[47:16], LPF_SH);
				next_r.pwr[0] = gain_y + r.poff[0];
				next_r.st = ST_PWR2;
			end
			ST_PWR2: begin
				next_r.plpf[1] = step(r.plpf[1], p2, LPF_SH);
				next_r.pwr[1] = gain_y + r.poff[1];
				next_r.app = app_prod[63:32];
				next_r.st = ST_IDLE;
			end
			default: next_r.st = ST_IDLE;
		endcase
		// stopping abandons the sample and leaves all results standing
		if (!run)
			next_r.st = ST_IDLE;
		next_r.rdy = (next_r.st == ST_IDLE) & next_r.ctl1[B_POWER_CALC_ENABLE]
			& ~next_r.det[B_GT];
	end
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			r <= '0;
			r.ctl1 <= RST_CTL;
			r.ctl3 <= RST_CTL;
			r.det <= RST_CTL;
			r.bpc <= RST_BPC;
			r.st <= ST_IDLE;
		end else if (ce_i) begin
			r <= next_r;
		end
	end
	assign wb_dat_o = r.dat;
	assign wb_ack_o = r.ack;
	assign smp_ready_o = r.rdy;

	// ---------------------------------------------------------------
	// assertions
	// ---------------------------------------------------------------
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i || !ce_i);
	a_off_no_ready: assert property (!run |-> !smp_ready_o)
		else $error("sample accepted while computation is off");
	a_gate_holds: assert property (!run |=> $stable(r.inst)
		&& $stable(r.avg) && $stable(r.app))
		else $error("results changed while stopped");
	a_bpf_bypass: assert property ((take && !r.ctl3[B_BANDPASS_ENABLE])
		|=> r.yp[$past(cs)] == $past(xs))
		else $error("bypassed filter altered the sample");
	a_root_bound: assert property ((r.st == ST_ROOT)
		|-> ##[1:40] (r.st != ST_ROOT))
		else $error("square root did not finish");
	a_inst_store: assert property ((r.st == ST_RCAL && run)
		|=> r.inst[$past(r.ch)] == $past(gain_y))
		else $error("instantaneous rms not stored from gain");
	a_avg_track: assert property ((r.st == ST_RCAL && run
		&& $signed(gain_y) > $signed(r.avg[r.ch]))
		|=> $signed(r.avg[$past(r.ch)])
		>= $signed($past(r.avg[r.ch])))
		else $error("average moved away from new value");
	a_reset_clear: assert property (@(posedge clk_i)
		disable iff (1'b0) rst_i
		|=> (r.inst == '0 && r.avg == '0 && r.app == 32'h0))
		else $error("results not cleared by reset");
	a_app_prod: assert property ((r.st == ST_PWR2 && run)
		|=> r.app == $past(app_prod[63:32]))
		else $error("apparent power is not the rms product");
	a_path_seq: assert property ((r.st == ST_RCAL && run
		&& r.ch == CH_U) |=> r.st == ST_PWR1
		##1 (r.st == ST_PWR2 || !$past(run)))
		else $error("power paths not computed after voltage");
	c_full_pass: cover property (take ##[1:60] r.st == ST_PWR2);
	c_gated: cover property (r.ctl1[B_POWER_CALC_ENABLE] && r.det[B_GT]);
	c_dual_active: cover property (r.st == ST_PWR2 && r.ctl3[B_DBL]);
	c_bpf_on: cover property (take && r.ctl3[B_BANDPASS_ENABLE]);

endmodule

// >>> verilog/rac_gain.sv
// rac_gain: y = x * (1 + s), s signed with 31 fraction bits, saturating
// assumes a combinational use inside the caller's cycle
module rac_gain import rac_pkg::*; (
	// operands
	input  wire logic [31:0] x_i,
	input  wire logic [31:0] s_i,
	// result
	output logic [31:0]      y_o
);

	logic signed [63:0] prod;
	logic signed [33:0] sum;

	always_comb begin
		prod = $signed(x_i) * $signed(s_i);
		sum = $signed({{2{x_i[31]}}, x_i}) + $signed({prod[63], prod[63:31]});
		// clamp instead of wrapping
		if (sum > 34'sh07FFFFFFF)
			y_o = 32'h7FFFFFFF;
		else if (sum < -34'sh080000000)
			y_o = 32'h80000000;
		else
			y_o = sum[31:0];
	end

endmodule

// >>> verilog/rac_pkg.sv
// rac_pkg: register indices, field positions, reset values and states
// assumes nothing beyond a single metering clock domain
package rac_pkg;

	// ---------------------------------------------------------------
	// register indices (byte address is four times the index)
	// ---------------------------------------------------------------
	localparam logic [13:0] IX_BPC   = 14'h10EF;
	localparam logic [13:0] IX_CTL1  = 14'h2878;
	localparam logic [13:0] IX_CTL3  = 14'h287A;
	localparam logic [13:0] IX_DET   = 14'h2886;
	localparam logic [13:0] IX_INST  = 14'h10C0;
	localparam logic [13:0] IX_AVG   = 14'h10C4;
	localparam logic [13:0] IX_APP   = 14'h10C8;
	localparam logic [13:0] IX_PWR   = 14'h10C9;
	localparam logic [13:0] IX_RGAIN = 14'h10E0;
	localparam logic [13:0] IX_PGAIN = 14'h10E3;
	localparam logic [13:0] IX_POFF  = 14'h10E5;

	// ---------------------------------------------------------------
	// field positions and reset values
	// ---------------------------------------------------------------
	localparam int          B_POWER_CALC_ENABLE  = 4;
	localparam int          B_BANDPASS_ENABLE = 6;
	localparam int          B_DBL   = 4;
	localparam int          B_GT    = 7;
	localparam logic [7:0]  RST_CTL = 8'h00;
	localparam logic [31:0] RST_BPC = 32'h00000000;

	// ---------------------------------------------------------------
	// filter lengths and iteration counts
	// ---------------------------------------------------------------
	localparam int LPF_SH     = 6;
	localparam int AVG_SH     = 4;
	localparam int INT_SH     = 6;
	localparam int ROOT_STEPS = 32;

	// ---------------------------------------------------------------
	// sample channels and sequencer states
	// ---------------------------------------------------------------
	localparam logic [1:0] CH_U  = 2'h0;
	localparam logic [1:0] CH_I1 = 2'h1;
	localparam logic [1:0] CH_I2 = 2'h2;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_ROOT = 3'b001,
		ST_RCAL = 3'b010,
		ST_PWR1 = 3'b011,
		ST_PWR2 = 3'b100
	} rac_state_e;

endpackage

// >>> verilog/rac_sqrt.sv
// rac_sqrt: bit-serial square root, 64-bit radicand to 32-bit root
// assumes start_i is a one-cycle pulse; a new start restarts the unit
module rac_sqrt import rac_pkg::*; (
	// clock, reset, enable
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        ce_i,
	// request and answer
	input  wire logic        start_i,
	input  wire logic [63:0] rad_i,
	output logic             done_o,
	output logic [31:0]      root_o
);

	typedef struct packed {
		logic [63:0] op;
		logic [63:0] res;
		logic [63:0] one;
		logic [5:0]  cnt;
		logic        busy;
		logic        done;
	} rac_sqrt_s;

	rac_sqrt_s   r;
	rac_sqrt_s   next_r;
	logic [63:0] trial;

	always_comb begin
		next_r = r;
		next_r.done = 1'b0;
		trial = r.res + r.one;
		if (start_i) begin
			next_r.op = rad_i;
			next_r.res = 64'h0;
			next_r.one = 64'h4000000000000000;
			next_r.cnt = 6'h00;
			next_r.busy = 1'b1;
		end else if (r.busy) begin
			if (r.op >= trial) begin
				next_r.op = r.op - trial;
				next_r.res = (r.res >> 1) + r.one;
			end else begin
				next_r.res = r.res >> 1;
			end
			next_r.one = r.one >> 2;
			next_r.cnt = r.cnt + 6'h01;
			if (r.cnt == 6'(ROOT_STEPS - 1)) begin
				next_r.busy = 1'b0;
				next_r.done = 1'b1;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i)
			r <= '0;
		else if (ce_i)
			r <= next_r;
	end

	assign done_o = r.done;
	assign root_o = r.res[31:0];

endmodule
